// [rtl/boundary_scan_tap.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - State follows mode select on clock rise
// R2 - Test reset gives reset state, IDCODE
// R3 - Select-DR holds registers, branches on mode
// R4 - Capture-DR loads selected register, then branches
// R5 - Shift-DR shifts selected register, others hold
// R6 - Exit1/Exit2-DR go to update, pause, shift
// R7 - Pause-DR halts shifting, waits for mode high
// R8 - Update-DR latches shift path on fall
// R9 - Select-IR holds; high returns to reset
// R10 - Capture-IR loads fixed value on rise
// R11 - Shift-IR shifts instruction, others hold
// R12 - Exit1/Pause/Exit2-IR branch on mode select
// R13 - Update-IR falling edge sets current instruction
// R14 - Instruction register three bits, shift plus latch
// R15 - Decode selects boundary or identification register
// R16 - Bypass bit serves BYPASS, CLAMP, HIGHZ
// R17 - SAMPLE captures pins, shifts without disturbance
// R18 - EXTEST drives outputs from boundary latches
// R19 - IDCODE captures device code, shifts out
// R20 - HIGHZ floats every pad output
// R21 - CLAMP drives boundary latches, held steady
// R22 - Identification: 32 bits, LSB one, fields
// R23 - Captured instruction low bits are 01
// R24 - Reset and idle states hold or advance
module boundary_scan_tap
    import tap_pkg::*;
#(
    parameter int BSR_WIDTH = BSR_LEN,
    parameter logic [3:0] VERSION = ID_VERSION,
    // Arbitrary part and maker values
    parameter logic [15:0] PART = ID_PART,
    parameter logic [10:0] MAKER = ID_MAKER
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic test_clock_pin,
    input wire logic test_mode_select_pin,
    input wire logic test_data_in_pin,
    input wire logic test_reset_pin,
    output logic test_data_out_pin,
    output logic test_data_out_oe,
    input wire logic [BSR_WIDTH-1:0] core_out,
    input wire logic [BSR_WIDTH-1:0] pin_in,
    output logic [BSR_WIDTH-1:0] pad_out,
    output logic pad_oe,
    output logic [BSR_WIDTH-1:0] core_in,
    output logic [IR_WIDTH-1:0] cur_instr
);
    // ========================================
    // Pin sampling and edge finding
    logic [3:0] pins_s;
    logic tck_s, tms_s, tdi_s, trst_s;
    logic tck_prev_q, tck_prev_d;
    tap_ctl_if ctl_if();

    tap_pin_sync #(.WIDTH(4)) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin_in({test_reset_pin, test_data_in_pin, test_mode_select_pin,
                 test_clock_pin}),
        .pin_out(pins_s)
    );
    assign tck_s = pins_s[0];
    assign tms_s = pins_s[1];
    assign tdi_s = pins_s[2];
    assign trst_s = pins_s[3];

    assign tck_prev_d = tck_s;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_prev_d;
        end
    end
    assign ctl_if.tck_rise = tck_s & ~tck_prev_q;
    assign ctl_if.tck_fall = ~tck_s & tck_prev_q;
    assign ctl_if.tms = tms_s;

    tap_fsm u_fsm (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .trst_sync(trst_s),
        .ctl(ctl_if.ctl)
    );

    tap_state_t st;
    logic rise, fall;
    assign st = ctl_if.state;
    assign rise = ctl_if.tck_rise;
    assign fall = ctl_if.tck_fall;

    // ========================================
    // Instruction decode
    // R15 - register select decode
    function automatic logic sel_bsr(input logic [2:0] ins);
        sel_bsr = (ins == INS_SAMPLE) || (ins == INS_EXTEST);
    endfunction
    function automatic logic sel_id(input logic [2:0] ins);
        sel_id = (ins == INS_IDCODE);
    endfunction

    logic [31:0] id_code;
    // R22 - identification code layout
    assign id_code = {VERSION, PART, MAKER, 1'b1};

    // ========================================
    // Registers
    // R14 - shift plus latch
    logic [2:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [31:0] id_sh_q, id_sh_d, id_lat_q, id_lat_d;
    logic [BSR_WIDTH-1:0] bsr_sh_q, bsr_sh_d, bsr_lat_q, bsr_lat_d;
    logic byp_q, byp_d;
    logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
    logic upd_ir_fall_q, upd_ir_fall_d;

    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        id_sh_d = id_sh_q;
        id_lat_d = id_lat_q;
        bsr_sh_d = bsr_sh_q;
        bsr_lat_d = bsr_lat_q;
        byp_d = byp_q;
        tdo_d = tdo_q;
        tdo_oe_d = tdo_oe_q;
        upd_ir_fall_d = upd_ir_fall_q;
        if (rise) begin
            upd_ir_fall_d = 1'b0;
            case (st)
                // R10 - fixed ir capture
                // R23 - low bits 01
                ST_CAP_IR: ir_sh_d = IR_CAPTURE_VAL;
                // R11 - ir shift
                ST_SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[2:1]};
                // R4 - capture selected register
                ST_CAP_DR: begin
                    // R17 - sample pins
                    if (sel_bsr(ir_q)) begin
                        bsr_sh_d = pin_in;
                    end else if (sel_id(ir_q)) begin
                        // R19 - load device code
                        id_sh_d = id_code;
                    end else begin
                        byp_d = 1'b0;
                    end
                end
                // R5 - shift only the selected path
                ST_SHIFT_DR: begin
                    if (sel_bsr(ir_q)) begin
                        bsr_sh_d = {tdi_s, bsr_sh_q[BSR_WIDTH-1:1]};
                    end else if (sel_id(ir_q)) begin
                        id_sh_d = {tdi_s, id_sh_q[31:1]};
                    end else begin
                        // R16 - one bit bypass
                        byp_d = tdi_s;
                    end
                end
                default: begin
                end
            endcase
        end
        if (fall) begin
            // Serial output changes on the falling edge
            tdo_oe_d = (st == ST_SHIFT_DR) || (st == ST_SHIFT_IR);
            if (st == ST_SHIFT_IR) begin
                tdo_d = ir_sh_q[0];
            end else if (sel_bsr(ir_q)) begin
                tdo_d = bsr_sh_q[0];
            end else if (sel_id(ir_q)) begin
                tdo_d = id_sh_q[0];
            end else begin
                tdo_d = byp_q;
            end
            // R13 - update ir latch
            if (st == ST_UPD_IR && !upd_ir_fall_q) begin
                ir_d = ir_sh_q;
                upd_ir_fall_d = 1'b1;
            end
            // R8 - update dr latch
            if (st == ST_UPD_DR) begin
                if (sel_bsr(ir_q)) begin
                    bsr_lat_d = bsr_sh_q;
                end else if (sel_id(ir_q)) begin
                    id_lat_d = id_sh_q;
                end
            end
        end
        // R2 - reset forces idcode
        if (st == ST_RESET) begin
            ir_d = IR_RESET_VAL;
            tdo_oe_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_sh_q <= IR_CAPTURE_VAL;
            ir_q <= IR_RESET_VAL;
            id_sh_q <= '0;
            id_lat_q <= '0;
            bsr_sh_q <= '0;
            bsr_lat_q <= '0;
            byp_q <= 1'b0;
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
            upd_ir_fall_q <= 1'b0;
        end else begin
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
            id_sh_q <= id_sh_d;
            id_lat_q <= id_lat_d;
            bsr_sh_q <= bsr_sh_d;
            bsr_lat_q <= bsr_lat_d;
            byp_q <= byp_d;
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
            upd_ir_fall_q <= upd_ir_fall_d;
        end
    end

    // ========================================
    // Pad control
    logic test_drive;
    // R18 - extest and clamp drive latches
    // R21 - clamp holds latches
    assign test_drive = (ir_q == INS_EXTEST) || (ir_q == INS_CLAMP);
    always_comb begin
        pad_out = test_drive ? bsr_lat_q : core_out;
        // R20 - highz floats outputs
        pad_oe = (ir_q != INS_HIGHZ);
    end
    // Core sees pins untouched in all modes
    assign core_in = pin_in;
    assign cur_instr = ir_q;
    assign test_data_out_pin = tdo_q;
    assign test_data_out_oe = tdo_oe_q;

    // ========================================
    // Checks
    // R2 - reset state holds idcode
    AST_RESET_IDCODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_RESET) |=> (ir_q == INS_IDCODE))
        else $error("Reset state without IDCODE");
    // R13 - update ir loads shifted value
    AST_UPD_IR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_UPD_IR && fall && !upd_ir_fall_q) |=> (ir_q == $past(ir_sh_q)))
        else $error("Update-IR did not latch instruction");
    // R10 - capture ir fixed value
    AST_CAP_IR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_CAP_IR && rise) |=> (ir_sh_q[1:0] == 2'b01))
        else $error("Capture-IR value wrong");
    // R19 - idcode captured
    AST_CAP_ID: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_CAP_DR && rise && ir_q == INS_IDCODE)
        |=> (id_sh_q == id_code))
        else $error("IDCODE not captured");
    // R7 - pause keeps shift data
    AST_PAUSE_STABLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_PAUSE_DR) |=> $stable(bsr_sh_q) && $stable(id_sh_q))
        else $error("Data shifted in Pause-DR");
    // R20 - highz floats pads
    AST_HIGHZ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ir_q == INS_HIGHZ) |-> !pad_oe)
        else $error("Pads driven under HIGHZ");
    // R18 - extest drives latches
    AST_EXTEST: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ir_q == INS_EXTEST) |-> (pad_out == bsr_lat_q))
        else $error("EXTEST pads not from latches");
    // R5 - bypass shifts tdi
    AST_BYPASS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_SHIFT_DR && rise && ir_q == INS_BYPASS)
        |=> (byp_q == $past(tdi_s)))
        else $error("Bypass bit did not take input");
    // R3 - select dr holds
    AST_SELDR_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_SEL_DR) |=> $stable(bsr_sh_q) && $stable(id_sh_q)
        && $stable(byp_q))
        else $error("Test registers moved in Select-DR");
    // R9 - select ir holds
    AST_SELIR_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_SEL_IR) |=> $stable(ir_q) && $stable(ir_sh_q))
        else $error("Instruction moved in Select-IR");
    // R11 - ir shift takes input
    AST_IR_SHIFT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_SHIFT_IR && rise) |=> (ir_sh_q[2] == $past(tdi_s)))
        else $error("Instruction shift stage wrong");
    // R11 - instruction held in shift
    AST_SHIR_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_SHIFT_IR) |=> $stable(ir_q))
        else $error("Current instruction moved in Shift-IR");
    // R12 - pause ir holds
    AST_PAUSE_IR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_PAUSE_IR) |=> $stable(ir_sh_q) && $stable(ir_q))
        else $error("Instruction moved in Pause-IR");
    // R17 - sample captures pins
    AST_CAP_BSR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_CAP_DR && rise && sel_bsr(ir_q))
        |=> (bsr_sh_q == $past(pin_in)))
        else $error("Boundary capture wrong");
    // R16 - bypass captures zero
    AST_CAP_BYP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_CAP_DR && rise && ir_q == INS_BYPASS) |=> !byp_q)
        else $error("Bypass capture not zero");
    // R8 - boundary latch update
    AST_BSR_LATCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_UPD_DR && fall && sel_bsr(ir_q))
        |=> (bsr_lat_q == $past(bsr_sh_q)))
        else $error("Boundary latch not updated");
    // R22 - id latch update
    AST_ID_LATCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_UPD_DR && fall && sel_id(ir_q))
        |=> (id_lat_q == $past(id_sh_q)))
        else $error("Identification latch not updated");
    // R21 - clamp holds latches
    AST_CLAMP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ir_q == INS_CLAMP && $past(ir_q) == INS_CLAMP)
        |-> (pad_out == bsr_lat_q) && $stable(bsr_lat_q))
        else $error("Clamp outputs moved");
    // R2 - serial out off in reset
    AST_OE_RESET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st == ST_RESET) |=> !test_data_out_oe)
        else $error("Serial out driven in reset state");
    // R5 - serial out only in shift
    AST_OE_SHIFT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fall && st != ST_SHIFT_DR && st != ST_SHIFT_IR)
        |=> !test_data_out_oe)
        else $error("Serial out driven outside shift");
    // R16 - normal pads when not driving
    AST_NORMAL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ir_q == INS_SAMPLE || ir_q == INS_BYPASS || ir_q == INS_IDCODE)
        |-> (pad_out == core_out) && pad_oe)
        else $error("Pads disturbed by test logic");

    // ========================================
    // Cover points
    COV_IDCODE_SHIFT: cover property (@(posedge ref_clk)
        st == ST_SHIFT_DR && ir_q == INS_IDCODE);
    COV_EXTEST: cover property (@(posedge ref_clk) ir_q == INS_EXTEST);
    COV_HIGHZ: cover property (@(posedge ref_clk) ir_q == INS_HIGHZ);
endmodule
`default_nettype wire

// [rtl/tap_ctl_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tap_ctl_if;
    import tap_pkg::*;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    tap_state_t state;
    modport ctl (input tck_rise, input tck_fall, input tms, output state);
    modport user (input tck_rise, input tck_fall, input state);
endinterface
`default_nettype wire

// [rtl/tap_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module tap_fsm
    import tap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic trst_sync,
    tap_ctl_if.ctl ctl
);
    tap_state_t state_q, state_d;
    // ========================================
    // Sixteen-state controller
    always_comb begin
        state_d = state_q;
        // R1 - move on rise
        if (ctl.tck_rise) begin
            case (state_q)
                // R24 - reset and idle
                ST_RESET: state_d = ctl.tms ? ST_RESET : ST_IDLE;
                ST_IDLE: state_d = ctl.tms ? ST_SEL_DR : ST_IDLE;
                // R3 - select dr
                ST_SEL_DR: state_d = ctl.tms ? ST_SEL_IR : ST_CAP_DR;
                // R4 - capture dr
                ST_CAP_DR: state_d = ctl.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: state_d = ctl.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                // R6 - exit paths
                ST_EXIT1_DR: state_d = ctl.tms ? ST_UPD_DR : ST_PAUSE_DR;
                // R7 - pause dr
                ST_PAUSE_DR: state_d = ctl.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: state_d = ctl.tms ? ST_UPD_DR : ST_SHIFT_DR;
                // R8 - update dr exit
                ST_UPD_DR: state_d = ctl.tms ? ST_SEL_DR : ST_IDLE;
                // R9 - select ir
                ST_SEL_IR: state_d = ctl.tms ? ST_RESET : ST_CAP_IR;
                // R10 - capture ir exit
                ST_CAP_IR: state_d = ctl.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                // R11 - shift ir exit
                ST_SHIFT_IR: state_d = ctl.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                // R12 - ir exits and pause
                ST_EXIT1_IR: state_d = ctl.tms ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: state_d = ctl.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: state_d = ctl.tms ? ST_UPD_IR : ST_SHIFT_IR;
                // R13 - update ir exit
                ST_UPD_IR: state_d = ctl.tms ? ST_SEL_DR : ST_IDLE;
                default: state_d = ST_RESET;
            endcase
        end
        // R2 - test reset wins
        if (!trst_sync) begin
            state_d = ST_RESET;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end
    assign ctl.state = state_q;

    // ========================================
    // Checks
    // R1 - moves only on tck rise
    AST_MOVE_ON_RISE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!ctl.tck_rise && trst_sync) |=> $stable(state_q))
        else $error("State moved without a test clock rise");
    // R9 - select ir to reset
    AST_SEL_IR_RESET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_q == ST_SEL_IR && ctl.tck_rise && ctl.tms)
        |=> state_q == ST_RESET)
        else $error("Select-IR with mode high did not reset");
    // R7 - pause dr hold
    AST_PAUSE_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_q == ST_PAUSE_DR && ctl.tck_rise && !ctl.tms && trst_sync)
        |=> state_q == ST_PAUSE_DR)
        else $error("Pause-DR left with mode low");
    // R24 - reset to idle
    AST_RESET_IDLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_q == ST_RESET && ctl.tck_rise && !ctl.tms && trst_sync)
        |=> state_q == ST_IDLE)
        else $error("Reset state did not go to idle");
    COV_SHIFT_IR: cover property (@(posedge ref_clk) state_q == ST_SHIFT_IR);
    COV_PAUSE_DR: cover property (@(posedge ref_clk) state_q == ST_PAUSE_DR);
endmodule
`default_nettype wire

// [rtl/tap_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tap_pin_sync
    import tap_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    // ========================================
    // Three stages; a change counts when 2 and 3 agree
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;
    always_comb begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            out_q <= out_d;
        end
    end
    assign pin_out = out_q;
endmodule
`default_nettype wire

// [rtl/tap_pkg.sv]
package tap_pkg;
    // ========================================
    // Instruction register
    localparam int IR_WIDTH = 3;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE = 3'h2;
    localparam logic [2:0] INS_CLAMP = 3'h3;
    localparam logic [2:0] INS_HIGHZ = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
    localparam logic [2:0] IR_RESET_VAL = INS_IDCODE;
    // ========================================
    // Identification code fields, part and maker values arbitrary
    localparam int ID_WIDTH = 32;
    localparam logic [3:0] ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART = 16'h0abc;
    localparam logic [10:0] ID_MAKER = 11'h055;
    // ========================================
    // Default boundary chain length
    localparam int BSR_LEN = 8;
    // ========================================
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_t;
endpackage

// [sim/boundary_scan_tap_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_tb_top;
    import tap_pkg::*;
    // ========================================
    // Identity values, arbitrary
    localparam logic [3:0] T_VER = 4'h3;
    localparam logic [15:0] T_PART = 16'h1234;
    localparam logic [10:0] T_MAKER = 11'h02a5;
    localparam logic [31:0] T_ID = {T_VER, T_PART, T_MAKER, 1'h1};
    logic ref_clk, arst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, pad_oe;
    logic [7:0] core_out, pin_in, pad_out, core_in;
    logic [2:0] cur_instr;
    int n_mismatch, check_count;
    // ========================================
    // Design and tester
    boundary_scan_tap #(.BSR_WIDTH(8), .VERSION(T_VER), .PART(T_PART),
        .MAKER(T_MAKER)) i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .test_clock_pin(tck),
        .test_mode_select_pin(tms), .test_data_in_pin(tdi),
        .test_reset_pin(trst_n), .test_data_out_pin(tdo),
        .test_data_out_oe(tdo_oe), .core_out(core_out), .pin_in(pin_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in),
        .cur_instr(cur_instr)
    );
    tap_tester i_tester (
        .test_clock_pin(tck), .test_mode_select_pin(tms),
        .test_data_in_pin(tdi), .test_reset_pin(trst_n),
        .test_data_out_pin(tdo)
    );
    // ========================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what,
                seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            i_tester.step(seq[i], 1'h0, q);
        end
    endtask
    // Last bit leaves with mode high, into Exit1
    task automatic shift(input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic q;
        dout = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            i_tester.step(i == n - 1, din[i], q);
            dout[i] = q;
            if (i < n - 1) chk(tdo_oe, 1'h1, "tdo enable");
        end
    endtask
    task automatic set_pins(input logic [7:0] co, input logic [7:0] pi);
        @(negedge ref_clk);
        core_out <= co;
        pin_in <= pi;
        #7;
    endtask
    // From idle: capture, exit1, pause twice, exit2, shift
    task automatic load_ir(input logic [2:0] code);
        logic [31:0] cap;
        logic [2:0] old;
        old = cur_instr;
        walk(8'h4b, 8);
        shift(3, {29'h0, code}, cap);
        chk(cap[2:0], IR_CAPTURE_VAL, "ir capture");
        chk(cur_instr, old, "instr held in shift");
        walk(8'h01, 2);
        chk(cur_instr, code, "instr update");
    endtask
    task automatic scan_dr(input int n, input logic [31:0] din,
        output logic [31:0] dout);
        walk(8'h01, 3);
        shift(n, din, dout);
        walk(8'h01, 2);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        chk(cur_instr, INS_IDCODE, "reset instr");
        chk(pad_oe, 1'h1, "reset pads on");
        chk(pad_out, core_out, "reset pads normal");
        chk(tdo_oe, 1'h0, "tdo off");
    endtask
    // Pause in mid-scan, then 33 bits prove the 32-bit length
    task automatic t_idcode();
        logic [31:0] lo, hi;
        walk(8'h01, 3);
        shift(16, 32'h0000_0001, lo);
        walk(8'h04, 4);
        shift(17, 32'h0000_0000, hi);
        chk({hi[15:0], lo[15:0]}, T_ID, "idcode");
        chk(hi[16], 1'h1, "id length");
        walk(8'h01, 2);
        chk(cur_instr, INS_IDCODE, "instr kept");
    endtask
    task automatic t_boundary();
        logic [31:0] out;
        set_pins(8'ha5, 8'h3c);
        load_ir(INS_SAMPLE);
        scan_dr(8, 32'h0000_0096, out);
        chk(out[7:0], 8'h3c, "sample capture");
        chk(pad_out, 8'ha5, "sample no effect");
        chk(core_in, 8'h3c, "core input");
        load_ir(INS_EXTEST);
        chk(pad_out, 8'h96, "extest drive");
        set_pins(8'h5a, 8'hc3);
        scan_dr(8, 32'h0000_000f, out);
        chk(out[7:0], 8'hc3, "extest capture");
        chk(pad_out, 8'h0f, "update latch");
    endtask
    // Captured zero, then input delayed by one stage
    task automatic t_bypass();
        logic [2:0] codes [3];
        logic [31:0] out;
        codes = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            scan_dr(4, 32'h0000_000b, out);
            chk(out[3:0], 4'h6, "bypass path");
            chk(pad_oe, codes[k] != INS_HIGHZ, "pad enable");
            if (codes[k] == INS_BYPASS) begin
                chk(pad_out, core_out, "bypass normal");
            end
            if (codes[k] == INS_CLAMP) begin
                set_pins(8'h77, 8'h11);
                chk(pad_out, 8'h0f, "clamp held");
            end
        end
    endtask
    task automatic t_tlr();
        load_ir(INS_BYPASS);
        walk(8'h0f, 4);
        chk(cur_instr, INS_IDCODE, "select-ir to reset");
        walk(8'h00, 1);
        load_ir(INS_SAMPLE);
        i_tester.pulse_reset();
        chk(cur_instr, INS_IDCODE, "test reset");
        walk(8'h00, 1);
        t_idcode();
    endtask
    // ========================================
    // Clock, watchdog, main sequence
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #1_500_000;
        $display("MISMATCH %0t run timed out", $time);
        n_mismatch++;
        test_done();
    end
    initial begin
        arst_n = 1'h0;
        core_out = 8'h00;
        pin_in = 8'h00;
        n_mismatch = 0;
        check_count = 0;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n <= 1'h1;
        repeat (5) @(negedge ref_clk);
        #7;
        t_reset();
        walk(8'h00, 1);
        t_idcode();
        t_boundary();
        t_bypass();
        t_tlr();
        test_done();
    end
endmodule
`default_nettype wire

// [sim/tap_tester.sv]
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
    output logic test_clock_pin,
    output logic test_mode_select_pin,
    output logic test_data_in_pin,
    output logic test_reset_pin,
    input wire logic test_data_out_pin
);
    // ========================================
    // Idle levels
    // Clock stands low between frames
    initial begin
        test_clock_pin = 1'h0;
        test_mode_select_pin = 1'h1;
        test_data_in_pin = 1'h0;
        test_reset_pin = 1'h1;
    end
    // ========================================
    // One test clock period
    // mode before rise
    task automatic step(input logic m, input logic d, output logic q);
        test_mode_select_pin = m;
        test_data_in_pin = d;
        #80;
        test_clock_pin = 1'h1;
        // Late sample, tdo trails the fall by the sync delay
        #79;
        q = test_data_out_pin;
        #1;
        test_clock_pin = 1'h0;
    endtask
    // ========================================
    // Test reset pulse
    task automatic pulse_reset();
        test_reset_pin = 1'h0;
        #400;
        test_reset_pin = 1'h1;
        #240;
    endtask
endmodule
`default_nettype wire
